// ==== dv/can_pin_props.sv ====
// assertion checker for the pin control
`timescale 1ns/100ps
`default_nettype none
module can_pin_props (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_low_power_off_mode,
    input wire logic i_txd,
    input wire logic i_txd_driven,
    input wire logic i_bus_dominant,
    input wire can_xcvr_pkg::bus_fault_type i_bus_fault,
    input wire can_xcvr_pkg::bus_ctrl_type o_bus_ctrl,
    input wire logic o_rxd,
    input wire logic o_rxd_oe,
    input wire logic o_dominant_timeout
);
    wire lp = i_low_power_off_mode, to = o_dominant_timeout, rec = i_txd | !i_txd_driven;
    wire flt = |i_bus_fault, off_w = !(o_bus_ctrl.drv_h_en | o_bus_ctrl.drv_l_en);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    AST_ON: assert property ($past(i_rst_n) && !$past(lp) && !lp && !rec && !flt && !to
        |=> o_bus_ctrl.drv_h_en && o_bus_ctrl.drv_l_en || to || flt) else $error("not driving");
    AST_OFF: assert property (rec || lp |=> off_w) else $error("driving");
    AST_LP: assert property (lp |=> o_bus_ctrl.pulldown_en && off_w) else $error("off mode");
    AST_RX: assert property ($past(i_rst_n) |-> o_rxd == !$past(i_bus_dominant)) else $error("rxd");
    AST_OE: assert property ($past(i_rst_n) |-> o_rxd_oe == !$past(lp)) else $error("rxd enable");
    AST_FLT: assert property (flt && $past(flt) |-> off_w) else $error("fault");
    AST_TO: assert property (to |=> off_w) else $error("timeout");
    AST_HOLD: assert property (to && !rec && !lp |=> to) else $error("left timeout");
    cover property (to);
    cover property (lp ##1 !o_rxd_oe);
    cover property (flt ##1 flt);
endmodule // can_pin_props
bind can_transceiver_pin_control can_pin_props can_pin_props_i (.*);
`default_nettype wire

// ==== dv/mcu_can_ctrl.sv ====
// protocol controller model on the transmit pin
`timescale 1ns/100ps
`default_nettype none
module mcu_can_ctrl (
    input wire logic i_dom,
    input wire logic i_float,
    output logic o_txd,
    output logic o_txd_driven
);
    // a released pin rests on the device pull-up
    assign o_txd = i_float | !i_dom;
    assign o_txd_driven = !i_float;
endmodule // mcu_can_ctrl
`default_nettype wire

// ==== dv/testbench.sv ====
// bench for the pin control
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_low_power_off_mode, i_bus_dominant, i_txd, i_txd_driven, dom, flt;
    can_xcvr_pkg::bus_fault_type i_bus_fault;
    can_xcvr_pkg::bus_ctrl_type o_bus_ctrl;
    logic o_txd_pull_up_en, o_txd_pull_down_en, o_io_supply_en, o_transceiver_supply_regulator_en;
    logic o_rxd, o_rxd_oe, o_dominant_timeout;
    int fail_count = 0, num_checks = 0;
    wire [6:0] st = {o_bus_ctrl[3:2], o_bus_ctrl[0], o_txd_pull_down_en, o_rxd, o_rxd_oe, o_dominant_timeout};
    can_transceiver_pin_control can_transceiver_pin_control_i (.*);
    mcu_can_ctrl mcu_can_ctrl_i (.i_dom(dom), .i_float(flt), .o_txd(i_txd), .o_txd_driven(i_txd_driven));
    initial forever #4 i_sys_clk = ~i_sys_clk;
    task automatic check(input string name, input logic [6:0] exp, input logic [6:0] seen);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step(input logic d, f, b, l, input logic [1:0] fl, input int n, input logic [6:0] e);
        {dom, flt, i_bus_dominant, i_low_power_off_mode, i_bus_fault} = {d, f, b, l, fl};
        repeat (n) @(posedge i_sys_clk);
        #1;
        check("status", e, st);
        check("bias", {6'h00, !e[4]}, {6'h00, o_bus_ctrl.bias_en});
        check("pull-up", {6'h00, !e[3]}, {6'h00, o_txd_pull_up_en});
        check("io supply", {6'h00, !e[3]}, {6'h00, o_io_supply_en});
        check("regulator", {6'h00, i_rst_n}, {6'h00, o_transceiver_supply_regulator_en});
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic t_drive();
        step(0, 0, 0, 0, 2'h0, 2, 7'h06);
        step(1, 0, 1, 0, 2'h0, 2, 7'h62);
        step(1, 1, 0, 0, 2'h0, 2, 7'h06);
    endtask
    task automatic t_refuse();
        for (int i = 1; i < 4; i++) step(1, 0, 0, 0, 2'(i), 2, 7'h06);
        step(1, 0, 0, 1, 2'h0, 2, 7'h1c);
    endtask
    // the long wait is the real figure; the timer length is not reachable from the top
    task automatic t_timeout();
        step(1, 0, 1, 0, 2'h0, can_xcvr_pkg::DOM_TIMEOUT_CYC - can_xcvr_pkg::CLK_MHZ, 7'h62);
        step(1, 0, 1, 0, 2'h0, 4 * can_xcvr_pkg::CLK_MHZ, 7'h03);
        step(0, 0, 0, 0, 2'h0, 2, 7'h06);
        step(1, 0, 1, 0, 2'h0, 2, 7'h62);
    endtask
    initial begin
        step(0, 0, 0, 0, 2'h0, 6, 7'h1c);
        i_rst_n = 1'b1;
        t_drive();
        t_refuse();
        t_timeout();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        fail_count++;
        wrap_up();
    end
endmodule // testbench
`default_nettype wire

// ==== logic/can_transceiver_pin_control.sv ====
// top: transmit pin to bus driver mapping, receive report and mode control
`timescale 1ns/100ps
`default_nettype none
// Contract
// - normal, transmit high: both drivers off
// - normal, transmit low: both drivers on
// - long dominant request disables bus driving
// - undriven transmit input reads as recessive
// - low power off pulls transmit input low
// - normal: receive driven high recessive, low dominant
// - low power off: receive high impedance
// - low power off: drivers off, bus pulled down
// - normal recessive keeps bus biasing on
// - transceiver supply regulator on after start-up
// - overload or overtemperature restricts bus driving
module can_transceiver_pin_control (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_low_power_off_mode,
    input wire logic i_txd,
    input wire logic i_txd_driven,
    input wire logic i_bus_dominant,
    input wire can_xcvr_pkg::bus_fault_type i_bus_fault,
    output can_xcvr_pkg::bus_ctrl_type o_bus_ctrl,
    output logic o_txd_pull_up_en,
    output logic o_txd_pull_down_en,
    output logic o_io_supply_en,
    output logic o_transceiver_supply_regulator_en,
    output logic o_rxd,
    output logic o_rxd_oe,
    output logic o_dominant_timeout
);
    can_xcvr_pkg::xcvr_state_type state_r;
    can_xcvr_pkg::xcvr_state_type state_nxt;
    can_xcvr_pkg::bus_ctrl_type bus_ctrl_r;
    can_xcvr_pkg::bus_ctrl_type bus_ctrl_nxt;
    logic [7:0] div_r;
    logic tick_r;
    logic rxd_r;
    logic rxd_oe_r;
    logic pu_r;
    logic pd_r;
    logic reg_en_r;
    wire logic expired;
    wire logic txd_level;
    wire logic dom_req;
    wire logic fault;
    wire logic normal;
    wire logic drive;

    // floating input reads as idle through the pull-up; off mode forces low
    assign txd_level = i_low_power_off_mode ? 1'b0 : (i_txd_driven ? i_txd : can_xcvr_pkg::TXD_IDLE);
    // off mode drops normal without the state register; bus controls and state both update on the next edge
    assign normal = (state_r != can_xcvr_pkg::ST_OFF) && !i_low_power_off_mode;
    // the controller owns i_txd; nothing here drives it
    assign dom_req = normal && !txd_level;
    assign fault = i_bus_fault.over_current || i_bus_fault.over_temp;
    assign drive = (state_r == can_xcvr_pkg::ST_NORMAL) && dom_req && !fault;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else begin
            div_r <= (div_r == can_xcvr_pkg::TICK_DIV) ? '0 : div_r + 1'b1;
            tick_r <= (div_r == can_xcvr_pkg::TICK_DIV);
        end
    end

    dominant_timer u_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_tick(tick_r),
        .i_dominant_req(dom_req),
        .o_expired(expired)
    );

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            can_xcvr_pkg::ST_OFF: begin
                if (!i_low_power_off_mode) begin
                    state_nxt = can_xcvr_pkg::ST_NORMAL;
                end
            end
            can_xcvr_pkg::ST_NORMAL: begin
                if (i_low_power_off_mode) begin
                    state_nxt = can_xcvr_pkg::ST_OFF;
                end else if (expired) begin
                    state_nxt = can_xcvr_pkg::ST_TIMEOUT;
                end
            end
            can_xcvr_pkg::ST_TIMEOUT: begin
                if (i_low_power_off_mode) begin
                    state_nxt = can_xcvr_pkg::ST_OFF;
                end else if (txd_level) begin
                    state_nxt = can_xcvr_pkg::ST_NORMAL;
                end
            end
        endcase
    end

    always_comb begin
        bus_ctrl_nxt.drv_h_en = drive;
        bus_ctrl_nxt.drv_l_en = drive;
        bus_ctrl_nxt.bias_en = normal;
        bus_ctrl_nxt.pulldown_en = !normal;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= can_xcvr_pkg::ST_OFF;
            bus_ctrl_r <= '{drv_h_en: 1'b0, drv_l_en: 1'b0, bias_en: 1'b0, pulldown_en: 1'b1};
            rxd_r <= can_xcvr_pkg::RXD_IDLE;
            rxd_oe_r <= 1'b0;
            pu_r <= 1'b0;
            pd_r <= 1'b1;
            reg_en_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bus_ctrl_r <= bus_ctrl_nxt;
            rxd_r <= !i_bus_dominant;
            rxd_oe_r <= !i_low_power_off_mode;
            pu_r <= !i_low_power_off_mode;
            pd_r <= i_low_power_off_mode;
            reg_en_r <= 1'b1;
        end
    end

    // one cycle of register latency; far below any bus bit time
    assign o_bus_ctrl = bus_ctrl_r;
    assign o_rxd = rxd_r;
    assign o_rxd_oe = rxd_oe_r;
    assign o_txd_pull_up_en = pu_r;
    assign o_txd_pull_down_en = pd_r;
    assign o_io_supply_en = pu_r;
    assign o_transceiver_supply_regulator_en = reg_en_r;
    assign o_dominant_timeout = (state_r == can_xcvr_pkg::ST_TIMEOUT);
endmodule // can_transceiver_pin_control
`default_nettype wire

// ==== logic/can_xcvr_pkg.sv ====
// package: constants and carrier types for the can transceiver pin control
`default_nettype none
package can_xcvr_pkg;
    // dominant timeout in microseconds; a chosen figure, kept short so a full run stays brief
    localparam int unsigned DOM_TIMEOUT_US = 100;
    localparam int unsigned CLK_MHZ = 125;
    // longest time in whole cycles: microseconds times clock MHz, exact
    localparam int unsigned DOM_TIMEOUT_CYC = DOM_TIMEOUT_US * CLK_MHZ;
    localparam int unsigned CNT_W = 32;
    // local time base: one enable pulse per microsecond
    localparam logic [7:0] TICK_DIV = 8'(CLK_MHZ - 1);
    localparam logic TXD_IDLE = 1'b1;
    localparam logic RXD_IDLE = 1'b1;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_NORMAL,
        ST_TIMEOUT
    } xcvr_state_type;

    typedef struct packed {
        logic drv_h_en;
        logic drv_l_en;
        logic bias_en;
        logic pulldown_en;
    } bus_ctrl_type;

    typedef struct packed {
        logic over_current;
        logic over_temp;
    } bus_fault_type;
endpackage
`default_nettype wire

// ==== logic/dominant_timer.sv ====
// dominant timeout supervisor on a microsecond enable
`timescale 1ns/100ps
`default_nettype none
module dominant_timer #(
    parameter int unsigned TIMEOUT_US = can_xcvr_pkg::DOM_TIMEOUT_US
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_tick,
    input wire logic i_dominant_req,
    output logic o_expired
);
    logic [can_xcvr_pkg::CNT_W-1:0] cnt_r;
    logic [can_xcvr_pkg::CNT_W-1:0] cnt_nxt;
    logic expired_r;
    logic expired_nxt;
    wire logic at_limit;
    assign at_limit = (cnt_r >= can_xcvr_pkg::CNT_W'(TIMEOUT_US));
    // counts while dominant is requested, clears at recessive
    assign cnt_nxt = !i_dominant_req ? '0 : ((i_tick && !at_limit) ? cnt_r + 1'b1 : cnt_r);
    // expiry holds until the request returns recessive
    assign expired_nxt = i_dominant_req && (expired_r || (i_tick && at_limit));
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
            expired_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            expired_r <= expired_nxt;
        end
    end
    assign o_expired = expired_r;
endmodule // dominant_timer
`default_nettype wire
